// File: hdl/nand_codeword_llp_control.v
// Purpose: Codeword sizing, scrambler, delay-line calibration, interrupts and list fetch control
// Assumes: AHB-Lite slave on hclk; engine-side strobes are on hclk; flash_dqs is asynchronous
// Notes:   Reads take one wait state, writes none; unmapped reads return zero
`include "nand_cw_regs.vh"

module nand_codeword_llp_control (
  input  wire        hclk,            // Bus clock
  input  wire        hresetn,         // Async reset, active low
  input  wire        hsel,            // Slave select
  input  wire [11:0] haddr,           // Byte address
  input  wire [1:0]  htrans,          // Transfer type
  input  wire        hwrite,          // Write when high
  input  wire [2:0]  hsize,           // Transfer size, word only
  input  wire        hready,          // Bus ready
  input  wire [31:0] hwdata,          // Write data
  output reg  [31:0] hrdata,          // Read data
  output reg         hreadyout,       // Slave ready
  output reg         hresp,           // Always OKAY
  input  wire [9:0]  irq_src,         // Interrupt source pulses
  output reg         irq,             // Interrupt output
  input  wire        cw_start,        // Codeword start pulse
  input  wire        page_start,      // Page start pulse
  input  wire        to_flash,        // High when programming
  input  wire        data_in_valid,   // Byte strobe in
  input  wire [7:0]  data_in,         // Byte in
  output reg         data_in_ready,   // Low while seed is sent
  output reg         data_out_valid,  // Byte strobe out
  output reg  [7:0]  data_out,        // Byte out
  output reg  [10:0] page_bytes,      // Page bytes per codeword
  output reg  [7:0]  spare_bytes,     // Spare bytes to flash, plus parity with LBA off
  output reg  [10:0] page_stride,     // External page stride
  output reg  [7:0]  spare_stride,    // External spare stride
  output reg  [10:0] fill_bytes,      // Redundancy fill count
  input  wire        flash_dqs,       // Strobe from flash, async
  output reg  [7:0]  dqs_delay_count, // Applied delay elements
  output reg         fetch_req,       // List group fetch request
  output reg  [31:0] fetch_addr,      // Aligned group address
  input  wire        fetch_ack,       // Group loaded
  input  wire [31:0] fetch_next,      // Next pointer, zero ends
  output reg         exec_start,      // Group execute pulse
  input  wire        exec_done,       // Group execution done
  input  wire        match_valid,     // Read word for match
  input  wire [15:0] match_rdata      // Read word
);

  localparam S_IDLE  = 3'b001;
  localparam S_FETCH = 3'b010;
  localparam S_EXEC  = 3'b100;

  reg [31:0] xfer_ctl, ecc_ctl, scr_cfg, dly_cfg0, dly_cfg1;
  reg [31:0] list_ctl, mxfer_cfg, flash_op;
  reg [9:0]  int_en, int_pend;
  reg [11:0] a_addr;
  reg        a_wr, a_rd;
  reg [14:0] lfsr;
  reg [1:0]  seed_cnt;
  reg [19:0] seed_rx;
  reg        dqs_s1, dqs_s2, dqs_s3;
  reg        dly_busy, dly_lock;
  reg [7:0]  dly_count, dly_total;
  reg [2:0]  list_state;
  reg [31:0] list_ptr;
  reg        match_hit;
  reg [31:0] next_rdata;

  wire scr_on  = xfer_ctl[`XC_BYPASS_XFER] == 1'b0 && scr_cfg[`SC_ENABLE];
  wire lba_on  = xfer_ctl[`XC_LBA_ON];
  wire wr_xfer = a_wr && hready;
  wire [2:0] spare_cfg = xfer_ctl[`XC_SPARE_LO+2:`XC_SPARE_LO];
  wire [1:0] qtr = dly_cfg1[`DC1_QTR_LO+1:`DC1_QTR_LO];
  wire [9:0] clr_bits = (wr_xfer && a_addr == `OFS_INT_CLR) ? hwdata[9:0] : 10'h000;
  wire       launch = wr_xfer && a_addr == `OFS_DLY_CFG1 && hwdata[`DC1_START];
  wire       dqs_rise = dqs_s2 && !dqs_s3;
  // Start only on a write that sets enable, so a finished list is not rerun
  wire       list_kick = wr_xfer && a_addr == `OFS_LIST_CTL && hwdata[`LC_ENABLE];

  // Eight LFSR steps per byte; poly 0 taps x^15,x^1, poly 1 taps x^15,x^14
  function [14:0] lfsr_step8;
    input [14:0] s;
    input        p;
    integer      i;
    reg   [14:0] t;
    begin
      t = s;
      for (i = 0; i < 8; i = i + 1) begin
        t = {t[13:0], p ? (t[14] ^ t[13]) : (t[14] ^ t[0])};
      end
      lfsr_step8 = t;
    end
  endfunction

  function [7:0] parity_bytes;
    input [2:0] strength;
    begin
      case (strength)
        3'h0:    parity_bytes = `PAR_24;
        3'h1:    parity_bytes = `PAR_40;
        3'h2:    parity_bytes = `PAR_60;
        default: parity_bytes = `PAR_70;
      endcase
    end
  endfunction

  // Address phase capture and register writes
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_addr    <= 12'h000;
      a_wr      <= 1'b0;
      a_rd      <= 1'b0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= `RST_WORD;
      xfer_ctl  <= `RST_WORD;
      ecc_ctl   <= `RST_WORD;
      scr_cfg   <= `RST_WORD;
      dly_cfg0  <= `RST_WORD;
      dly_cfg1  <= `RST_WORD;
      list_ctl  <= `RST_WORD;
      mxfer_cfg <= `RST_WORD;
      flash_op  <= `RST_WORD;
      int_en    <= 10'h000;
    end else begin
      a_wr <= 1'b0;
      if (hsel && htrans[1] && hready) begin
        a_addr <= {haddr[11:2], 2'b00};
        a_wr   <= hwrite;
      end
      // Reads stall one cycle so a write just before them is already visible
      if (hsel && htrans[1] && hready && !hwrite) begin
        a_rd      <= 1'b1;
        hreadyout <= 1'b0;
      end else if (a_rd) begin
        a_rd      <= 1'b0;
        hreadyout <= 1'b1;
        hrdata    <= next_rdata;
      end
      if (wr_xfer) begin
        case (a_addr)
          `OFS_XFER_CTL:  xfer_ctl  <= hwdata;
          `OFS_ECC_CTL:   ecc_ctl   <= hwdata;
          `OFS_SCR_CFG:   scr_cfg   <= hwdata;
          `OFS_DLY_CFG0:  dly_cfg0  <= hwdata;
          `OFS_DLY_CFG1:  dly_cfg1  <= hwdata;
          `OFS_INT_EN:    int_en    <= hwdata[9:0];
          `OFS_LIST_CTL:  list_ctl  <= hwdata;
          `OFS_MXFER_CFG: mxfer_cfg <= hwdata;
          `OFS_FLASH_OP:  flash_op  <= hwdata;
          default:        ;
        endcase
      end
    end
  end

  always @* begin
    case (a_addr)
      `OFS_XFER_CTL:  next_rdata = xfer_ctl;
      `OFS_ECC_CTL:   next_rdata = ecc_ctl;
      `OFS_SCR_CFG:   next_rdata = scr_cfg;
      `OFS_DLY_CFG0:  next_rdata = dly_cfg0;
      `OFS_DLY_CFG1:  next_rdata = dly_cfg1;
      `OFS_DLY_OBS:   next_rdata = {15'h0000, dqs_delay_count, dly_total, dly_lock};
      `OFS_INT_EN:    next_rdata = {22'h000000, int_en};
      `OFS_INT_PEND:  next_rdata = {22'h000000, int_pend};
      `OFS_LIST_CTL:  next_rdata = list_ctl;
      `OFS_LIST_PROG: next_rdata = {list_ptr[31:6], 5'h00, list_state != S_IDLE};
      `OFS_MXFER_CFG: next_rdata = mxfer_cfg;
      `OFS_FLASH_OP:  next_rdata = flash_op;
      `OFS_SIZES:     next_rdata = {page_stride, spare_bytes, spare_stride, 5'h00};
      `OFS_STATUS:    next_rdata = {11'h000, match_hit, seed_rx};
      default:        next_rdata = `RST_WORD;
    endcase
  end

  // Codeword and stride sizing
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      page_bytes   <= `CW_FULL;
      spare_bytes  <= `SPARE_RAW;
      page_stride  <= `CW_FULL;
      spare_stride <= `SPARE_RAW;
      fill_bytes   <= 11'h000;
    end else begin
      fill_bytes <= mxfer_cfg[26:16];
      if (!lba_on) begin
        page_bytes  <= ecc_ctl[`EC_HALF_PAGE] ? `CW_HALF : `CW_FULL;
        // Small select is ignored here; stride stays full
        page_stride <= `CW_FULL;
        spare_bytes <= `SPARE_RAW + parity_bytes(ecc_ctl[`EC_STRENGTH_LO+2:`EC_STRENGTH_LO]);
        spare_stride <= xfer_ctl[`XC_STATUS_XFER] ? `SPARE_STATUS : `SPARE_RAW;
      end else begin
        page_bytes   <= xfer_ctl[`XC_SMALL_CW] ? `CW_HALF : `CW_FULL;
        page_stride  <= xfer_ctl[`XC_SMALL_CW] ? `CW_HALF : `CW_FULL;
        spare_stride <= `SPARE_RAW;
        // Clamp protects the engine if software oversteps the limit
        spare_bytes <= {5'h00, (spare_cfg > `SPARE_MAX) ? `SPARE_MAX : spare_cfg};
      end
    end
  end

  // Scrambler byte path with optional seed exchange
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lfsr           <= 15'h0000;
      seed_cnt       <= 2'h0;
      seed_rx        <= 20'h00000;
      data_in_ready  <= 1'b1;
      data_out_valid <= 1'b0;
      data_out       <= 8'h00;
    end else begin
      data_out_valid <= 1'b0;
      if (page_start && scr_on && xfer_ctl[`XC_SEED_SEND]) begin
        seed_cnt      <= `SEED_BYTES;
        data_in_ready <= !to_flash;
      end else if (seed_cnt != 2'h0 && to_flash) begin
        data_out_valid <= 1'b1;
        data_out       <= (seed_cnt == 2'h3) ? {4'h0, scr_cfg[19:16]} :
                          (seed_cnt == 2'h2) ? scr_cfg[15:8] : scr_cfg[7:0];
        seed_cnt       <= seed_cnt - 2'h1;
        data_in_ready  <= (seed_cnt == 2'h1);
      end else if (seed_cnt != 2'h0 && data_in_valid) begin
        seed_rx  <= {seed_rx[11:0], data_in};
        seed_cnt <= seed_cnt - 2'h1;
      end else if (cw_start) begin
        lfsr <= scr_cfg[14:0] == 15'h0000 ? 15'h7FFF : scr_cfg[14:0];
      end else if (data_in_valid) begin
        data_out_valid <= 1'b1;
        data_out       <= scr_on ? (data_in ^ lfsr[7:0]) : data_in;
        if (scr_on) begin
          lfsr <= lfsr_step8(lfsr, scr_cfg[`SC_POLY_SEL]);
        end
      end
    end
  end

  // Strobe synchroniser; stage one feeds only stage two
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dqs_s1 <= 1'b0;
      dqs_s2 <= 1'b0;
      dqs_s3 <= 1'b0;
    end else begin
      dqs_s1 <= flash_dqs;
      dqs_s2 <= dqs_s1;
      dqs_s3 <= dqs_s2;
    end
  end

  // Delay-line calibration: count steps from start point until a strobe edge
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dly_busy        <= 1'b0;
      dly_lock        <= 1'b0;
      dly_count       <= 8'h00;
      dly_total       <= 8'h00;
      dqs_delay_count <= 8'h00;
    end else if (launch) begin
      dly_lock <= 1'b0;
      if (hwdata[`DC1_BYPASS]) begin
        dly_busy        <= 1'b0;
        dly_lock        <= 1'b1;
        dqs_delay_count <= dly_cfg0[23:16];
      end else begin
        dly_busy  <= 1'b1;
        dly_count <= dly_cfg0[7:0];
      end
    end else if (dly_busy) begin
      if (dqs_rise) begin
        dly_busy  <= 1'b0;
        dly_lock  <= 1'b1;
        dly_total <= dly_count;
        case (qtr)
          2'b01:   dqs_delay_count <= {2'b00, dly_count[7:2]};
          2'b10:   dqs_delay_count <= {3'b000, dly_count[7:3]};
          default: dqs_delay_count <= dly_cfg0[15:8];
        endcase
      end else begin
        // Saturate rather than wrap when the strobe is slow
        dly_count <= (dly_count > 8'hFF - dly_cfg1[11:4]) ? 8'hFF
                   : dly_count + dly_cfg1[11:4];
      end
    end
  end

  // Interrupt pending; a new event wins over a clear in the same cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_pend <= 10'h000;
      irq      <= 1'b0;
    end else begin
      int_pend <= (int_pend & ~clr_bits) | irq_src;
      irq      <= |(((int_pend & ~clr_bits) | irq_src) & int_en);
    end
  end

  // List fetch and execute sequencer
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      list_state <= S_IDLE;
      list_ptr   <= `RST_WORD;
      fetch_req  <= 1'b0;
      fetch_addr <= `RST_WORD;
      exec_start <= 1'b0;
    end else begin
      exec_start <= 1'b0;
      case (list_state)
        S_IDLE: begin
          if (list_kick) begin
            list_ptr   <= {hwdata[31:6], 6'h00};
            fetch_addr <= {hwdata[31:6], 6'h00};
            fetch_req  <= 1'b1;
            list_state <= S_FETCH;
          end
        end
        S_FETCH: begin
          if (fetch_ack) begin
            fetch_req  <= 1'b0;
            list_ptr   <= {fetch_next[31:6], 6'h00};
            exec_start <= 1'b1;
            list_state <= S_EXEC;
          end
        end
        S_EXEC: begin
          // Next group waits for this one; enable cleared means stop here
          if (exec_done) begin
            if (list_ctl[`LC_ENABLE] && list_ptr != `RST_WORD) begin
              fetch_addr <= list_ptr;
              fetch_req  <= 1'b1;
              list_state <= S_FETCH;
            end else begin
              list_state <= S_IDLE;
            end
          end
        end
        default: list_state <= S_IDLE;
      endcase
    end
  end

  // Match against pattern for match-kind operations
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      match_hit <= 1'b0;
    end else if (match_valid && flash_op[`OP_KIND_LO+2:`OP_KIND_LO] == `OP_KIND_MATCH) begin
      match_hit <= flash_op[`OP_CMP_MODE]
                 ? ((match_rdata & flash_op[15:0]) == flash_op[15:0])
                 : ((match_rdata | flash_op[15:0]) == flash_op[15:0]);
    end
  end

endmodule

// File: hdl/nand_cw_regs.vh
// Purpose: Register offsets, field positions and reset values of the codeword/list control block
// Assumes: 32-bit AHB-Lite word registers, byte addresses
// Notes:   Included by nand_codeword_llp_control.v and by the self-checking bench
`ifndef NAND_CW_REGS_VH
`define NAND_CW_REGS_VH
`define OFS_XFER_CTL    12'h000
`define OFS_ECC_CTL     12'h004
`define OFS_SCR_CFG     12'h008
`define OFS_DLY_CFG0    12'h00C
`define OFS_DLY_CFG1    12'h010
`define OFS_DLY_OBS     12'h014
`define OFS_INT_EN      12'h018
`define OFS_INT_PEND    12'h01C
`define OFS_INT_CLR     12'h020
`define OFS_LIST_CTL    12'h024
`define OFS_LIST_PROG   12'h028
`define OFS_MXFER_CFG   12'h02C
`define OFS_FLASH_OP    12'h030
`define OFS_SIZES       12'h034
`define OFS_STATUS      12'h038
`define XC_BYPASS_XFER  3
`define XC_SEED_SEND    9
`define XC_LBA_ON       11
`define XC_SPARE_LO     12
`define XC_STATUS_XFER  19
`define XC_SMALL_CW     21
`define EC_HALF_PAGE    16
`define EC_STRENGTH_LO  25
`define SC_ENABLE       31
`define SC_POLY_SEL     30
`define DC1_START       0
`define DC1_BYPASS      1
`define DC1_QTR_LO      2
`define DC1_INCR_LO     4
`define LC_ENABLE       0
`define LC_MODE         1
`define OP_KIND_LO      16
`define OP_CMP_MODE     19
`define OP_KIND_MATCH   3'h3
`define RST_WORD        32'h00000000
`define SEED_BYTES      2'h3
`define CW_FULL         11'h400
`define CW_HALF         11'h200
`define SPARE_RAW       8'h04
`define SPARE_STATUS    8'h08
`define PAR_24          8'h2A
`define PAR_40          8'h46
`define PAR_60          8'h69
`define PAR_70          8'h7B
`define SPARE_MAX       3'h4
`endif

// File: bench/nand_list_partner.sv
// Purpose: Far-side model: list memory, group executor, read strobe
// Assumes: Requests come from the block on hclk
// Notes:   slow stretches every answer; strobe idles low outside bursts
module nand_list_partner #(
  parameter logic [31:0] LAST = 32'h100000C0
) (
  input  wire         hclk,       // Bus clock
  input  wire         hresetn,    // Reset, active low
  input  wire         slow,       // Late answers
  input  wire         dqs_run,    // Strobe burst on
  input  wire         fetch_req,  // Group request
  input  wire  [31:0] fetch_addr, // Group address
  input  wire         exec_start, // Execute pulse
  output logic        fetch_ack,  // Group loaded
  output logic [31:0] fetch_next, // Next pointer
  output logic        exec_done,  // Group finished
  output logic        flash_dqs   // Read strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  int fw;
  int ew;
  initial begin
    flash_dqs = 1'b0;
    #7;
    forever begin
      #100;
      flash_dqs = dqs_run ? ~flash_dqs : 1'b0;
    end
  end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fetch_ack <= 1'b0;
      exec_done <= 1'b0;
      fetch_next <= 32'h0;
      fw <= 0;
      ew <= 0;
    end else begin
      fetch_ack <= 1'b0;
      exec_done <= 1'b0;
      // Pointer inverts every cycle outside the ack cycle, so the old value returns every second cycle
      fetch_next <= ~fetch_next;
      if (fetch_req && !fetch_ack) begin
        fw <= fw + 1;
        if (fw >= (slow ? 6 : 1)) begin
          fw <= 0;
          fetch_ack <= 1'b1;
          fetch_next <= (fetch_addr == LAST) ? 32'h0 : fetch_addr + 32'h40;
        end
      end
      if (exec_start) begin
        ew <= slow ? 12 : 2;
      end else if (ew != 0) begin
        ew <= ew - 1;
        exec_done <= (ew == 1);
      end
    end
  end
endmodule

// File: bench/nand_cw_checker_assertions.sv
// Purpose: Port-level checks of the codeword/list control block
// Assumes: One hclk domain, hresetn async active low
// Notes:   Bound to every instance of the block
module nand_cw_checker (
  input wire        hclk,           // Bus clock
  input wire        hresetn,        // Reset, active low
  input wire        hsel,           // Slave select
  input wire [1:0]  htrans,         // Transfer type
  input wire        hwrite,         // Write when high
  input wire        hready,         // Bus ready
  input wire        hreadyout,      // Slave ready
  input wire        hresp,          // Response
  input wire        cw_start,       // Codeword start
  input wire        to_flash,       // Write direction
  input wire        data_in_valid,  // Byte in strobe
  input wire        data_in_ready,  // Byte accepted
  input wire        data_out_valid, // Byte out strobe
  input wire [10:0] page_stride,    // Page stride
  input wire [7:0]  spare_stride,   // Spare stride
  input wire        fetch_req,      // Group request
  input wire [31:0] fetch_addr,     // Group address
  input wire        fetch_ack,      // Group loaded
  input wire        exec_start      // Execute pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire take = hsel && htrans[1] && hready;

  a_hresp_okay: assert property (hresp == 1'b0)
    else $error("hresp not OKAY");
  a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_nowait: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  a_byte_forward: assert property (
    to_flash && data_in_valid && data_in_ready && !cw_start |=> data_out_valid)
    else $error("byte not forwarded");
  a_fetch_hold: assert property (
    fetch_req && !fetch_ack |=> fetch_req && $stable(fetch_addr))
    else $error("fetch request dropped");
  a_fetch_align: assert property (fetch_req |-> fetch_addr[5:0] == 6'h00)
    else $error("fetch address unaligned");
  a_exec_after_ack: assert property (
    fetch_req && fetch_ack |=> exec_start ##1 !exec_start)
    else $error("no execute pulse after load");
  a_no_overlap: assert property (exec_start |-> !fetch_req)
    else $error("fetch during execute start");
  a_stride_pair: assert property (spare_stride == 8'h08 |-> page_stride == 11'h400)
    else $error("status stride outside raw mode");
  a_stride_legal: assert property (
    page_stride == 11'h400 || page_stride == 11'h200)
    else $error("page stride illegal");
endmodule

bind nand_codeword_llp_control nand_cw_checker nand_cw_checker_inst (
  .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp, .cw_start,
  .to_flash, .data_in_valid, .data_in_ready, .data_out_valid, .page_stride,
  .spare_stride, .fetch_req, .fetch_addr, .fetch_ack, .exec_start);

// File: bench/test_nand_codeword_llp_control.sv
// Purpose: Self-checking bench of the codeword/list control block
// Assumes: Single slave, hready fed from hreadyout
// Notes:   Every wait is bounded; a spent bound ends the run
`include "nand_cw_regs.vh"
module test_nand_codeword_llp_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, cw_start = 0, page_start = 0;
  logic        to_flash = 1, data_in_valid = 0, match_valid = 0, slow = 0, dqs_run = 0;
  logic [11:0] haddr = 0;
  logic [1:0]  htrans = 0;
  logic [9:0]  irq_src = 0;
  logic [7:0]  data_in = 0, data_out, spare_bytes, spare_stride, dqs_delay_count, e;
  logic [15:0] match_rdata = 0;
  logic [31:0] hwdata = 0, hrdata, fetch_addr, fetch_next, r;
  logic [10:0] page_bytes, page_stride, fill_bytes;
  logic        hreadyout, hresp, irq, data_in_ready, data_out_valid;
  logic        flash_dqs, fetch_req, fetch_ack, exec_start, exec_done;
  logic [14:0] s;
  int          failures = 0, checked = 0, ndone = 0, n;
  logic [7:0]  outq[$];
  logic [31:0] fq[$];
  localparam logic [7:0]  PAR[4] = '{8'h2E, 8'h4A, 8'h6D, 8'h7F};
  localparam logic [7:0]  PAT[3] = '{8'h00, 8'hFF, 8'h3C};
  localparam logic [17:0] MT[4] = '{18'h10030, 18'h00130, 18'h301F0, 18'h20170};

  nand_codeword_llp_control nand_codeword_llp_control_inst (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hready(hreadyout),
    .hwdata, .hrdata, .hreadyout, .hresp, .irq_src, .irq, .cw_start, .page_start,
    .to_flash, .data_in_valid, .data_in, .data_in_ready, .data_out_valid, .data_out,
    .page_bytes, .spare_bytes, .page_stride, .spare_stride, .fill_bytes, .flash_dqs,
    .dqs_delay_count, .fetch_req, .fetch_addr, .fetch_ack, .fetch_next, .exec_start,
    .exec_done, .match_valid, .match_rdata);
  nand_list_partner nand_list_partner_inst (
    .hclk, .hresetn, .slow, .dqs_run, .fetch_req, .fetch_addr, .exec_start,
    .fetch_ack, .fetch_next, .exec_done, .flash_dqs);

  always #12.5 hclk = ~hclk;
  always @(posedge hclk) begin
    if (data_out_valid) outq.push_back(data_out);
    if (fetch_req && fetch_ack) fq.push_back(fetch_addr);
    if (exec_done) ndone++;
  end

  task automatic finish_test;
    if (failures == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (g !== x) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge hclk);
  endtask
  task automatic give_up(input int k);
    if (k >= 100) begin
      failures++;
      finish_test;
    end
  endtask
  // Entered and left just after a rising edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    hsel <= 1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do begin
      @(posedge hclk);
      k++;
    end while (!hreadyout && k < 100);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge hclk);
      k++;
    end while (!hreadyout && k < 100);
    r = hrdata;
    give_up(k);
  endtask
  task automatic poll(input logic [11:0] a, input int b, input logic v);
    int k;
    k = 0;
    xfer(0, a, 0);
    while (r[b] !== v && k < 100) begin
      xfer(0, a, 0);
      k++;
    end
    give_up(k);
  endtask
  task automatic send(input logic [7:0] b[3]);
    outq.delete();
    for (int i = 0; i < 3; i++) begin
      data_in <= b[i];
      data_in_valid <= 1;
      @(posedge hclk);
    end
    data_in_valid <= 0;
    tick(2);
  endtask
  task automatic pulse_cw;
    cw_start <= 1;
    tick(1);
    cw_start <= 0;
    tick(1);
  endtask
  function automatic logic [7:0] scr(inout logic [14:0] st, input logic p);
    logic [7:0] k;
    k = st[7:0];
    repeat (8) st = {st[13:0], p ? st[14] ^ st[13] : st[14] ^ st[0]};
    return k;
  endfunction

  initial begin
    tick(2);
    hresetn <= 1;
    chk("page_stride", 11'h400, page_stride);
    chk("spare_stride", 8'h04, spare_stride);
    tick(2);
    for (int i = 0; i < 4; i++) begin
      xfer(1, `OFS_ECC_CTL, i << 25);
      tick(2);
      chk("spare_bytes", PAR[i], spare_bytes);
      chk("page_bytes", 11'h400, page_bytes);
    end
    xfer(1, `OFS_ECC_CTL, 32'h00010000);
    tick(2);
    chk("page_bytes", 11'h200, page_bytes);
    chk("page_stride", 11'h400, page_stride);
    xfer(1, `OFS_ECC_CTL, 32'h0);
    xfer(1, `OFS_XFER_CTL, 32'h00080000);
    tick(2);
    chk("spare_stride", 8'h08, spare_stride);
    xfer(1, `OFS_XFER_CTL, 32'h00287800);
    tick(2);
    chk("page_bytes", 11'h200, page_bytes);
    chk("page_stride", 11'h200, page_stride);
    chk("spare_stride", 8'h04, spare_stride);
    chk("spare_bytes", 8'h04, spare_bytes);
    xfer(1, `OFS_XFER_CTL, 32'h00283800);
    xfer(0, `OFS_SIZES, 0);
    chk("sizes", 32'h40006080, r);
    xfer(1, 12'h03C, 32'hFFFFFFFF);
    xfer(0, 12'h03C, 0);
    chk("unmapped", 32'h0, r);
    xfer(1, `OFS_MXFER_CFG, 32'h01550000);
    tick(2);
    chk("fill_bytes", 11'h155, fill_bytes);
    xfer(1, `OFS_XFER_CTL, 32'h0);
    for (int p = 0; p < 2; p++) begin
      xfer(1, `OFS_SCR_CFG, 32'h800A5C3E | (p << 30));
      pulse_cw();
      send(PAT);
      s = 15'h5C3E;
      for (int i = 0; i < 3; i++) begin
        e = PAT[i] ^ scr(s, p[0]);
        chk("scrambled", e, outq[i]);
      end
    end
    xfer(1, `OFS_XFER_CTL, 32'h00000008);
    pulse_cw();
    send(PAT);
    for (int i = 0; i < 3; i++) chk("bypassed", PAT[i], outq[i]);
    xfer(1, `OFS_SCR_CFG, 32'h800ABCDE);
    xfer(1, `OFS_XFER_CTL, 32'h00000200);
    outq.delete();
    page_start <= 1;
    tick(1);
    page_start <= 0;
    tick(1);
    chk("data_in_ready", 0, data_in_ready);
    tick(5);
    chk("seed_out", 32'h000ABCDE, {outq[0], outq[1], outq[2]});
    to_flash <= 0;
    page_start <= 1;
    tick(1);
    page_start <= 0;
    tick(1);
    send('{8'h05, 8'h43, 8'h21});
    xfer(0, `OFS_STATUS, 0);
    chk("seed_in", 20'h54321, r[19:0]);
    chk("seed_fwd", 0, outq.size());
    to_flash <= 1;
    xfer(1, `OFS_DLY_CFG0, 32'h00AB0000);
    xfer(1, `OFS_DLY_CFG1, 32'h00000003);
    tick(3);
    chk("delay", 8'hAB, dqs_delay_count);
    xfer(0, `OFS_DLY_OBS, 0);
    chk("obs", 9'h157, {r[16:9], r[0]});
    for (int q = 0; q < 3; q++) begin
      dqs_run <= 0;
      tick(10);
      xfer(1, `OFS_DLY_CFG0, 32'h00002A10);
      xfer(1, `OFS_DLY_CFG1, 32'h00000011 | (q << 2));
      dqs_run <= 1;
      poll(`OFS_DLY_OBS, 0, 1'b1);
      e = (q == 0) ? 8'h2A : r[8:1] >> (q + 1);
      chk("applied", e, r[16:9]);
      chk("delay", e, dqs_delay_count);
    end
    irq_src <= 10'h3FF;
    tick(1);
    irq_src <= 0;
    tick(2);
    chk("irq", 0, irq);
    xfer(0, `OFS_INT_PEND, 0);
    chk("pending", 32'h3FF, r);
    xfer(1, `OFS_INT_EN, 32'h3FF);
    tick(2);
    chk("irq", 1, irq);
    for (int i = 0; i < 10; i++) begin
      xfer(1, `OFS_INT_CLR, 1 << i);
      xfer(0, `OFS_INT_PEND, 0);
      chk("pending", 32'h3FF & ~((2 << i) - 1), r);
    end
    tick(2);
    chk("irq", 0, irq);
    fq.delete();
    xfer(1, `OFS_LIST_CTL, 32'h10000043);
    poll(`OFS_LIST_PROG, 0, 1'b0);
    chk("fetches", 3, fq.size());
    for (int i = 0; i < 3; i++) chk("fetch_addr", 32'h10000040 + 64 * i, fq[i]);
    fq.delete();
    ndone = 0;
    slow <= 1;
    xfer(1, `OFS_LIST_CTL, 32'h10000041);
    for (n = 0; n < 100 && exec_start !== 1'b1; n++) @(posedge hclk);
    give_up(n);
    xfer(1, `OFS_LIST_CTL, 32'h0);
    xfer(0, `OFS_LIST_PROG, 0);
    chk("busy", 1, r[0]);
    poll(`OFS_LIST_PROG, 0, 1'b0);
    chk("groups", 1, fq.size());
    chk("done", 1, ndone);
    for (int i = 0; i < 4; i++) begin
      xfer(1, `OFS_FLASH_OP, 32'h000300F0 | (MT[i][17] << 19));
      match_rdata <= MT[i][15:0];
      match_valid <= 1;
      tick(1);
      match_valid <= 0;
      tick(2);
      xfer(0, `OFS_STATUS, 0);
      chk("match", MT[i][16], r[20]);
    end
    finish_test;
  end
endmodule
